// >>> shared/usb_cond_cfg.svh
// Constants of the high-speed conditioner mode controller
`ifndef USB_COND_CFG_SVH
`define USB_COND_CFG_SVH

// ----------------------------------------------------------------
// Clock and chirp timing
// ----------------------------------------------------------------
`define CLK_PERIOD_NS 100
`define CHIRP_MIN_NS 18000
`define CHIRP_MAX_NS 128000
`define CHIRP_MIN_CYC ((`CHIRP_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CHIRP_MAX_CYC (`CHIRP_MAX_NS / `CLK_PERIOD_NS)
`define CHIRP_CNT_W 12

// ----------------------------------------------------------------
// Strap encodings
// ----------------------------------------------------------------
`define AC_BOOST_MAX 2'h3
`define DC_GAIN_40MV 2'h0
`define DC_GAIN_60MV 2'h1
`define DC_GAIN_80MV 2'h2

// ----------------------------------------------------------------
// Pin input synchroniser
// ----------------------------------------------------------------
`define PIN_IN_W 16
`define PIN_IN_RST 16'h0001

// ----------------------------------------------------------------
// Serial target
// ----------------------------------------------------------------
`define I2C_ADDR 7'h2C
`define I2C_BITS 4'h8
`define I2C_CNT_W 4

`endif

// >>> shared/usb_cond_pkg.sv
// Types shared by the conditioner mode controller
package usb_cond_pkg;
`include "usb_cond_cfg.svh"

    typedef enum logic [1:0] {
        DC_GAIN_40 = `DC_GAIN_40MV,
        DC_GAIN_60 = `DC_GAIN_60MV,
        DC_GAIN_80 = `DC_GAIN_80MV
    } dc_gain_t;

    typedef struct packed {
        logic i2c_mode;
        logic [1:0] ac_level;
        dc_gain_t dc_gain;
    } strap_cfg_t;

    // Last field is the LSB; enable_n resets to 1 so the core holds off
    typedef struct packed {
        logic scl;
        logic sda;
        logic ac_float;
        logic [1:0] ac_level;
        logic dc_pull_up;
        logic dc_pull_down;
        logic pullup_det;
        logic disconnect_det;
        logic fixture_det;
        logic test_packet_det;
        logic usb_reset_det;
        logic chirp_j;
        logic chirp_k;
        logic squelch;
        logic enable_n;
    } pin_in_t;

    typedef enum logic [7:0] {
        L_UNCONN    = 8'h01,
        L_ATTACHED  = 8'h02,
        L_FIXTURE   = 8'h04,
        L_BUS_RESET = 8'h08,
        L_CHIRP_J   = 8'h10,
        L_CHIRP_K   = 8'h20,
        L_HS_PEND   = 8'h40,
        L_HS        = 8'h80
    } link_state_t;

    typedef enum logic [6:0] {
        I_IDLE = 7'h01,
        I_ADDR = 7'h02,
        I_AACK = 7'h04,
        I_WR   = 7'h08,
        I_WACK = 7'h10,
        I_RD   = 7'h20,
        I_RACK = 7'h40
    } i2c_state_t;
endpackage

// >>> src/pin_sync.sv
// Three-stage pin synchroniser with second/third stage agreement
`include "usb_cond_cfg.svh"

module pin_sync
    import usb_cond_pkg::*;
(
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic [`PIN_IN_W-1:0] pin_i,
    output logic [`PIN_IN_W-1:0] pin_o
);
    localparam logic [`PIN_IN_W-1:0] RST_VAL = `PIN_IN_RST;

    genvar g;
    generate
        for (g = 0; g < `PIN_IN_W; g++) begin : g_bit
            logic s1_r, s2_r, s3_r, out_r;
            logic s1_nxt, s2_nxt, s3_nxt, out_nxt;

            always_comb begin
                s1_nxt = pin_i[g];
                s2_nxt = s1_r;
                s3_nxt = s2_r;
                // A change counts only once two late stages agree
                out_nxt = (s2_r == s3_r) ? s3_r : out_r;
            end

            always_ff @(posedge clk_i) begin
                if (reset_i) begin
                    s1_r <= RST_VAL[g];
                    s2_r <= RST_VAL[g];
                    s3_r <= RST_VAL[g];
                    out_r <= RST_VAL[g];
                end else begin
                    s1_r <= s1_nxt;
                    s2_r <= s2_nxt;
                    s3_r <= s3_nxt;
                    out_r <= out_nxt;
                end
            end

            assign pin_o[g] = out_r;
        end
    endgenerate
endmodule

// >>> src/usb_hs_conditioner_mode_ctrl.sv
// Mode, strap and status-pin control of the high-speed conditioner
`include "usb_cond_cfg.svh"

// Behaviour
// - The AC boost strap is latched only at reset release and then ignored.
// - A floating AC boost strap at release selects the highest AC boost.
// - In pin-strap mode the DC gain pin is read as high 80, float 60, low 40.
// - After reset in pin-strap mode the DC gain pin outputs the HS flag.
// - HS flag sets after fixture detect from unconnected, then test packet.
// - HS flag sets on squelch after a reset with one 18-128 us J/K chirp pair.
// - Serial mode is entered only if both serial lines are high at release.
// - In serial mode the block answers as target 0x2C, data pin two-way.
// - Unused pins per mode (data in pin-strap, DC pin in serial) stay idle.
// - The core regulator is enabled only while the channel is high speed.
// - While the enable pin is low the block is held in reset and shutdown.
// - In pin-strap mode the clock pin outputs the attach flag.
module usb_hs_conditioner_mode_ctrl
    import usb_cond_pkg::*;
(
    input wire logic clk_i,
    input wire logic reset_i,
    input wire pin_in_t pins_i,
    output strap_cfg_t cfg_o,
    output logic shutdown_o,
    output logic core_regulator_output_en_o,
    output logic high_speed_active_flag_o,
    output logic high_speed_active_flag_oe_o,
    output logic attach_detect_flag_o,
    output logic attach_detect_flag_oe_o,
    output logic i2c_sda_o,
    output logic i2c_sda_oe_o,
    output logic [7:0] i2c_byte_o
);
    localparam logic [`CHIRP_CNT_W-1:0] CHIRP_MIN =
        `CHIRP_CNT_W'(`CHIRP_MIN_CYC);
    localparam logic [`CHIRP_CNT_W-1:0] CHIRP_MAX =
        `CHIRP_CNT_W'(`CHIRP_MAX_CYC);

    pin_in_t pins_s;
    logic core_rst;

    pin_sync u_sync (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .pin_i(pins_i),
        .pin_o(pins_s)
    );

    assign core_rst = reset_i | pins_s.enable_n;

    // ------------------------------------------------------------
    // Strap capture at reset release
    // ------------------------------------------------------------
    strap_cfg_t cfg_r, cfg_nxt;
    logic run_r, run_nxt;

    always_comb begin
        cfg_nxt = cfg_r;
        run_nxt = 1'b1;
        // Latched on the single cycle after release, frozen afterwards
        if (!run_r) begin
            cfg_nxt.i2c_mode = pins_s.scl & pins_s.sda;
            cfg_nxt.ac_level = pins_s.ac_float ? `AC_BOOST_MAX
                                               : pins_s.ac_level;
            if (pins_s.dc_pull_up) begin
                cfg_nxt.dc_gain = DC_GAIN_80;
            end else if (pins_s.dc_pull_down) begin
                cfg_nxt.dc_gain = DC_GAIN_40;
            end else begin
                cfg_nxt.dc_gain = DC_GAIN_60;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (core_rst) begin
            cfg_r <= '{i2c_mode: 1'b0, ac_level: `AC_BOOST_MAX,
                       dc_gain: DC_GAIN_60};
            run_r <= 1'b0;
        end else begin
            cfg_r <= cfg_nxt;
            run_r <= run_nxt;
        end
    end

    // ------------------------------------------------------------
    // Link state tracking
    // ------------------------------------------------------------
    link_state_t lst_r, lst_nxt;
    logic [`CHIRP_CNT_W-1:0] ccnt_r, ccnt_nxt;
    logic attach_r, attach_nxt;
    logic chirp_ok;

    assign chirp_ok = (ccnt_r >= CHIRP_MIN) && (ccnt_r <= CHIRP_MAX);

    always_comb begin
        lst_nxt = lst_r;
        ccnt_nxt = ccnt_r;
        attach_nxt = attach_r;
        if (lst_r == L_UNCONN && pins_s.pullup_det) begin
            attach_nxt = 1'b1;
        end
        if (pins_s.disconnect_det) begin
            attach_nxt = 1'b0;
            lst_nxt = L_UNCONN;
        end else begin
            case (lst_r)
                L_UNCONN: begin
                    if (pins_s.fixture_det) begin
                        lst_nxt = L_FIXTURE;
                    end else if (pins_s.pullup_det) begin
                        lst_nxt = L_ATTACHED;
                    end
                end
                L_FIXTURE: begin
                    if (pins_s.test_packet_det) begin
                        lst_nxt = L_HS;
                    end
                end
                L_ATTACHED: begin
                    if (pins_s.usb_reset_det) begin
                        lst_nxt = L_BUS_RESET;
                    end
                end
                L_BUS_RESET: begin
                    ccnt_nxt = '0;
                    if (pins_s.chirp_j) begin
                        lst_nxt = L_CHIRP_J;
                    end else if (!pins_s.usb_reset_det) begin
                        lst_nxt = L_ATTACHED;
                    end
                end
                L_CHIRP_J: begin
                    // Saturating just past the window keeps a stuck chirp out
                    if (pins_s.chirp_j) begin
                        if (ccnt_r <= CHIRP_MAX) begin
                            ccnt_nxt = ccnt_r + 1'b1;
                        end
                    end else begin
                        ccnt_nxt = '0;
                        lst_nxt = (chirp_ok && pins_s.chirp_k) ?
                                  L_CHIRP_K : L_ATTACHED;
                    end
                end
                L_CHIRP_K: begin
                    if (pins_s.chirp_k) begin
                        if (ccnt_r <= CHIRP_MAX) begin
                            ccnt_nxt = ccnt_r + 1'b1;
                        end
                    end else begin
                        ccnt_nxt = '0;
                        lst_nxt = chirp_ok ? L_HS_PEND : L_ATTACHED;
                    end
                end
                L_HS_PEND: begin
                    if (pins_s.squelch) begin
                        lst_nxt = L_HS;
                    end
                end
                L_HS: begin
                    if (pins_s.usb_reset_det) begin
                        lst_nxt = L_BUS_RESET;
                    end
                end
                default: begin
                    lst_nxt = L_UNCONN;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (core_rst) begin
            lst_r <= L_UNCONN;
            ccnt_r <= '0;
            attach_r <= 1'b0;
        end else begin
            lst_r <= lst_nxt;
            ccnt_r <= ccnt_nxt;
            attach_r <= attach_nxt;
        end
    end

    // ------------------------------------------------------------
    // Serial target
    // ------------------------------------------------------------
    i2c_state_t ist_r, ist_nxt;
    logic [`I2C_CNT_W-1:0] bcnt_r, bcnt_nxt;
    logic [7:0] sh_r, sh_nxt;
    logic [7:0] byte_r, byte_nxt;
    logic rw_r, rw_nxt;
    logic oe_r, oe_nxt;
    logic scl_q_r, sda_q_r;
    logic scl_rise, scl_fall, i2c_start, i2c_stop;
    logic [7:0] status_byte;

    assign scl_rise = pins_s.scl & ~scl_q_r;
    assign scl_fall = ~pins_s.scl & scl_q_r;
    assign i2c_start = pins_s.scl & scl_q_r & sda_q_r & ~pins_s.sda;
    assign i2c_stop = pins_s.scl & scl_q_r & ~sda_q_r & pins_s.sda;
    assign status_byte = {lst_r == L_HS, attach_r, cfg_r.i2c_mode,
                          cfg_r.ac_level, cfg_r.dc_gain, 1'b0};

    always_comb begin
        ist_nxt = ist_r;
        bcnt_nxt = bcnt_r;
        sh_nxt = sh_r;
        byte_nxt = byte_r;
        rw_nxt = rw_r;
        oe_nxt = oe_r;
        if (!run_r || !cfg_r.i2c_mode) begin
            ist_nxt = I_IDLE;
            oe_nxt = 1'b0;
        end else if (i2c_start) begin
            ist_nxt = I_ADDR;
            bcnt_nxt = '0;
            oe_nxt = 1'b0;
        end else if (i2c_stop) begin
            ist_nxt = I_IDLE;
            oe_nxt = 1'b0;
        end else begin
            case (ist_r)
                I_IDLE: begin
                    oe_nxt = 1'b0;
                end
                I_ADDR, I_WR: begin
                    if (scl_rise) begin
                        sh_nxt = {sh_r[6:0], pins_s.sda};
                        bcnt_nxt = bcnt_r + 1'b1;
                    end else if (scl_fall && bcnt_r == `I2C_BITS) begin
                        if (ist_r == I_WR) begin
                            ist_nxt = I_WACK;
                            byte_nxt = sh_r;
                            oe_nxt = 1'b1;
                        end else if (sh_r[7:1] == `I2C_ADDR) begin
                            ist_nxt = I_AACK;
                            rw_nxt = sh_r[0];
                            oe_nxt = 1'b1;
                        end else begin
                            ist_nxt = I_IDLE;
                        end
                    end
                end
                I_AACK, I_RACK: begin
                    if (ist_r == I_RACK && scl_rise && pins_s.sda) begin
                        ist_nxt = I_IDLE;
                    end else if (scl_fall) begin
                        bcnt_nxt = '0;
                        if (rw_r) begin
                            ist_nxt = I_RD;
                            sh_nxt = status_byte;
                            oe_nxt = ~status_byte[7];
                        end else begin
                            ist_nxt = I_WR;
                            oe_nxt = 1'b0;
                        end
                    end
                end
                I_WACK: begin
                    if (scl_fall) begin
                        ist_nxt = I_WR;
                        bcnt_nxt = '0;
                        oe_nxt = 1'b0;
                    end
                end
                I_RD: begin
                    if (scl_rise) begin
                        bcnt_nxt = bcnt_r + 1'b1;
                    end else if (scl_fall) begin
                        if (bcnt_r == `I2C_BITS) begin
                            ist_nxt = I_RACK;
                            oe_nxt = 1'b0;
                        end else begin
                            sh_nxt = {sh_r[6:0], 1'b0};
                            oe_nxt = ~sh_r[6];
                        end
                    end
                end
                default: begin
                    ist_nxt = I_IDLE;
                    oe_nxt = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (core_rst) begin
            ist_r <= I_IDLE;
            bcnt_r <= '0;
            sh_r <= 8'h00;
            byte_r <= 8'h00;
            rw_r <= 1'b0;
            oe_r <= 1'b0;
            scl_q_r <= 1'b1;
            sda_q_r <= 1'b1;
        end else begin
            ist_r <= ist_nxt;
            bcnt_r <= bcnt_nxt;
            sh_r <= sh_nxt;
            byte_r <= byte_nxt;
            rw_r <= rw_nxt;
            oe_r <= oe_nxt;
            scl_q_r <= pins_s.scl;
            sda_q_r <= pins_s.sda;
        end
    end

    // ------------------------------------------------------------
    // Output pins
    // ------------------------------------------------------------
    logic shut_r, core_regulator_output_r, hs_r, hs_oe_r, att_r, att_oe_r;
    logic shut_nxt, core_regulator_output_nxt, hs_nxt, hs_oe_nxt, att_nxt, att_oe_nxt;
    logic strap_mode;

    // Status pins only drive once the straps are safely latched
    assign strap_mode = run_r & ~cfg_r.i2c_mode;

    always_comb begin
        shut_nxt = core_rst;
        hs_nxt = ~core_rst & (lst_nxt == L_HS);
        core_regulator_output_nxt = hs_nxt;
        hs_oe_nxt = ~core_rst & strap_mode;
        att_nxt = ~core_rst & attach_nxt;
        att_oe_nxt = ~core_rst & strap_mode;
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            shut_r <= 1'b1;
            core_regulator_output_r <= 1'b0;
            hs_r <= 1'b0;
            hs_oe_r <= 1'b0;
            att_r <= 1'b0;
            att_oe_r <= 1'b0;
        end else begin
            shut_r <= shut_nxt;
            core_regulator_output_r <= core_regulator_output_nxt;
            hs_r <= hs_nxt;
            hs_oe_r <= hs_oe_nxt;
            att_r <= att_nxt;
            att_oe_r <= att_oe_nxt;
        end
    end

    assign cfg_o = cfg_r;
    assign shutdown_o = shut_r;
    assign core_regulator_output_en_o = core_regulator_output_r;
    assign high_speed_active_flag_o = hs_r;
    assign high_speed_active_flag_oe_o = hs_oe_r;
    assign attach_detect_flag_o = att_r;
    assign attach_detect_flag_oe_o = att_oe_r;
    // Open drain: the data line is only ever pulled low
    assign i2c_sda_o = 1'b0;
    assign i2c_sda_oe_o = oe_r;
    assign i2c_byte_o = byte_r;
endmodule

// >>> sim/mode_ctrl_asserts.sv
// Assertion checker for the conditioner mode controller
module mode_ctrl_asserts
    import usb_cond_pkg::*;
(
    input wire logic clk_i,
    input wire logic reset_i,
    input wire pin_in_t pins_i,
    input wire strap_cfg_t cfg_o,
    input wire logic shutdown_o,
    input wire logic core_regulator_output_en_o,
    input wire logic high_speed_active_flag_o,
    input wire logic high_speed_active_flag_oe_o,
    input wire logic attach_detect_flag_o,
    input wire logic attach_detect_flag_oe_o,
    input wire logic i2c_sda_o,
    input wire logic i2c_sda_oe_o,
    input wire logic [7:0] i2c_byte_o
);
    timeunit 1ns;
    timeprecision 100ps;

    default clocking @(posedge clk_i); endclocking
    default disable iff (reset_i);

    // ----------------
    // Sequences
    // ----------------
    // Long enough for the synchroniser and the state register to settle
    sequence s_run;
        !shutdown_o [*3];
    endsequence
    sequence s_disc;
        pins_i.disconnect_det [*8];
    endsequence
    sequence s_bus_reset;
        pins_i.usb_reset_det [*8];
    endsequence

    // ----------------
    // Properties
    // ----------------
    AST_RESET_OUT: assert property (
        $fell(reset_i) |-> shutdown_o && !core_regulator_output_en_o
        && !high_speed_active_flag_oe_o && !attach_detect_flag_oe_o
        && !i2c_sda_oe_o && cfg_o == 5'h0D)
        else $error("outputs not idle after reset");
    AST_ENABLE_LOW: assert property (
        pins_i.enable_n [*8] |-> shutdown_o)
        else $error("core runs while enable pin is low");
    AST_STRAP_HOLD: assert property (
        s_run ##1 !shutdown_o |-> $stable(cfg_o))
        else $error("strap setting changed while running");
    AST_OE_MODE: assert property (
        s_run |-> high_speed_active_flag_oe_o == !cfg_o.i2c_mode
        && attach_detect_flag_oe_o == high_speed_active_flag_oe_o)
        else $error("status pin enables wrong for mode");
    AST_SDA_IDLE: assert property (
        !cfg_o.i2c_mode |-> !i2c_sda_oe_o)
        else $error("data pin driven in pin-strap mode");
    AST_SDA_DRAIN: assert property (
        i2c_sda_oe_o |-> !i2c_sda_o)
        else $error("data pin driven high");
    AST_CORE_REGULATOR_OUTPUT_HS: assert property (
        high_speed_active_flag_oe_o |->
        core_regulator_output_en_o == high_speed_active_flag_o)
        else $error("regulator enable differs from high-speed flag");
    AST_DISC: assert property (
        s_disc |-> !attach_detect_flag_o && !high_speed_active_flag_o
        && !core_regulator_output_en_o)
        else $error("flags still set during disconnect");
    AST_BUS_RESET: assert property (
        s_bus_reset |-> !high_speed_active_flag_o)
        else $error("high-speed flag set during bus reset");
    AST_DC_CODE: assert property (
        cfg_o.dc_gain != 2'h3)
        else $error("undefined dc gain code");
endmodule

bind usb_hs_conditioner_mode_ctrl mode_ctrl_asserts chk (.clk_i, .reset_i,
    .pins_i, .cfg_o, .shutdown_o, .core_regulator_output_en_o,
    .high_speed_active_flag_o, .high_speed_active_flag_oe_o,
    .attach_detect_flag_o, .attach_detect_flag_oe_o, .i2c_sda_o,
    .i2c_sda_oe_o, .i2c_byte_o);

// >>> sim/usb_link_partner.sv
// Behavioural model of the host and device on the USB channel
module usb_link_partner (
    input wire logic clk_i,
    output logic [7:0] link_o
);
    timeunit 1ns;
    timeprecision 100ps;

    // ----------------
    // Link events
    // ----------------
    // Bits: pull-up, disconnect, fixture, test packet, bus reset,
    // chirp J, chirp K, squelch; a level stands until the next hold
    initial link_o = 8'h00;

    // Entered just after an edge, returns just after the last edge
    task automatic hold(input logic [7:0] v, input int n);
        link_o = v;
        repeat (n) @(posedge clk_i);
        #1;
    endtask

    // K rises one cycle before J drops so the pair stays back to back
    task automatic handshake(input int j, input int k);
        hold(8'h88, 20);
        hold(8'h84, j - 1);
        hold(8'h86, 1);
        hold(8'h82, k - 1);
        hold(8'h81, 10);
    endtask
endmodule

// >>> sim/tb.sv
// Self-checking bench of the conditioner mode controller
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    import usb_cond_pkg::*;

    logic clk_i = 1'h0;
    logic reset_i = 1'h1;
    logic scl = 1'h1;
    logic sda_pu = 1'h1;
    logic sda_low = 1'h0;
    logic en_n = 1'h1;
    logic [4:0] strap = 5'h00;
    logic [7:0] link;
    logic sda;
    logic ack;
    logic [7:0] rd;
    pin_in_t pins_i;
    strap_cfg_t cfg_o;
    logic shutdown_o, core_regulator_output_en_o;
    logic high_speed_active_flag_o, high_speed_active_flag_oe_o;
    logic attach_detect_flag_o, attach_detect_flag_oe_o;
    logic i2c_sda_o, i2c_sda_oe_o;
    logic [7:0] i2c_byte_o;
    // Rows: scl, sda pull-up, strap bits, expected setting
    logic [11:0] rows [4] = '{12'hC11, 12'hACE, 12'h528, 12'h085};
    int failures = 0;
    int n_tests = 0;

    // Open-drain data line: pulled up unless someone pulls it low
    assign sda = sda_pu & ~sda_low & ~(i2c_sda_oe_o & ~i2c_sda_o);
    assign pins_i = {scl, sda, strap, link, en_n};

    usb_hs_conditioner_mode_ctrl DUT (.clk_i, .reset_i, .pins_i, .cfg_o,
        .shutdown_o, .core_regulator_output_en_o, .high_speed_active_flag_o,
        .high_speed_active_flag_oe_o, .attach_detect_flag_o,
        .attach_detect_flag_oe_o, .i2c_sda_o, .i2c_sda_oe_o, .i2c_byte_o);
    usb_link_partner lp (.clk_i, .link_o(link));

    always #50 clk_i = ~clk_i;

    // ----------------
    // Helpers
    // ----------------
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic test_done();
        if (failures == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic core_reset();
        en_n = 1'h1;
        tick(8);
        check(8'(shutdown_o), 8'h01);
        en_n = 1'h0;
        tick(12);
        check(8'(shutdown_o), 8'h00);
    endtask

    // Slow bit timing leaves room for the three-flop synchroniser
    task automatic i2c_bit(input logic b, output logic s);
        sda_low = ~b;
        tick(6);
        scl = 1'h1;
        tick(4);
        s = sda;
        tick(4);
        scl = 1'h0;
        tick(2);
    endtask

    task automatic i2c_byte(input logic [7:0] b, output logic a);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            i2c_bit(b[i], s);
        end
        i2c_bit(1'h1, s);
        a = ~s;
    endtask

    // Target drives the byte MSB first; the master then answers NACK
    task automatic i2c_read(output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            i2c_bit(1'h1, d[i]);
        end
        i2c_bit(1'h1, s);
    endtask

    task automatic i2c_start();
        sda_low = 1'h1;
        tick(8);
        scl = 1'h0;
        tick(2);
    endtask

    task automatic i2c_stop();
        sda_low = 1'h1;
        tick(4);
        scl = 1'h1;
        tick(6);
        sda_low = 1'h0;
        tick(8);
    endtask

    // ----------------
    // Tests
    // ----------------
    initial begin
        tick(5);
        check({3'h0, cfg_o}, 8'h0D);
        check(8'(shutdown_o), 8'h01);
        reset_i = 1'h0;
        tick(2);
        for (int i = 0; i < 4; i++) begin
            {scl, sda_pu, strap} = rows[i][11:5];
            core_reset();
            check({3'h0, cfg_o}, {3'h0, rows[i][4:0]});
            check(8'(high_speed_active_flag_oe_o), {7'h0, ~rows[i][4]});
            check(8'(attach_detect_flag_oe_o), {7'h0, ~rows[i][4]});
            strap = ~strap;
            tick(10);
            check({3'h0, cfg_o}, {3'h0, rows[i][4:0]});
        end
        lp.hold(8'h80, 10);
        check(8'(attach_detect_flag_o), 8'h01);
        lp.handshake(200, 200);
        check(8'(high_speed_active_flag_o), 8'h01);
        check(8'(core_regulator_output_en_o), 8'h01);
        lp.hold(8'h88, 10);
        check(8'(high_speed_active_flag_o), 8'h00);
        check(8'(core_regulator_output_en_o), 8'h00);
        lp.handshake(150, 200);
        check(8'(high_speed_active_flag_o), 8'h00);
        lp.handshake(200, 1400);
        check(8'(high_speed_active_flag_o), 8'h00);
        lp.handshake(190, 1260);
        check(8'(high_speed_active_flag_o), 8'h01);
        lp.hold(8'h40, 10);
        check({6'h0, attach_detect_flag_o, high_speed_active_flag_o},
            8'h00);
        lp.hold(8'h10, 10);
        check(8'(high_speed_active_flag_o), 8'h00);
        lp.hold(8'h20, 10);
        lp.hold(8'h30, 10);
        check(8'(high_speed_active_flag_o), 8'h01);
        check(8'(core_regulator_output_en_o), 8'h01);
        lp.hold(8'h00, 2);
        // Both serial lines high at release select the serial target
        scl = 1'h1;
        sda_pu = 1'h1;
        core_reset();
        i2c_start();
        i2c_byte(8'h58, ack);
        check(8'(ack), 8'h01);
        i2c_byte(8'hA5, ack);
        check(8'(ack), 8'h01);
        i2c_stop();
        check(i2c_byte_o, 8'hA5);
        // Status: idle link, serial mode, floating AC strap, DC pin high
        i2c_start();
        i2c_byte(8'h59, ack);
        check(8'(ack), 8'h01);
        i2c_read(rd);
        check(rd, 8'h3C);
        i2c_stop();
        i2c_start();
        i2c_byte(8'h5A, ack);
        check(8'(ack), 8'h00);
        i2c_stop();
        test_done();
    end

    // Whole run is under 6000 cycles; this allows a wide margin
    initial begin
        #2000000;
        failures++;
        test_done();
    end
endmodule
